// ### logic/slp_hub.sv
// module: lock hub, eight lock bits plus in-use inventory
`default_nettype none
module slp_hub (
   input  wire logic clk,    // system clock
   input  wire logic rstn,   // async reset, active low
   slp_if.hub        bus     // request port from core side
);
   import slp_pkg::*;

   // ==========================================================
   // notes for users of the hub
   // ==========================================================
   // link timing: a request is taken on any rising clock edge that sees
   //    req_valid high; req_ready never drops, so there is no
   //    back-pressure and no queue inside the hub
   // the answer is registered: rsp_valid pulses for one cycle on
   //    the cycle after the taking edge, rsp_data holds until the
   //    next answer replaces it
   // back-to-back requests are legal every cycle; each one sees
   //    the state left by the one before, which is what makes the
   //    read-modify-write of a lock bit atomic
   // several cores: whatever merges them in front of this port
   //    must pass one request per cycle; the hub has no notion of
   //    which core asked, so answers go back in request order
   // check-out hands out the lowest-numbered free lock; a full
   //    pool answers all ones, read as -1 by a signed 4-bit view
   // release touches only the inventory, never the lock bit, so
   //    a core still holding the flag keeps its view intact
   // set and clear ignore the inventory entirely; keeping to
   //    checked-out locks is the cores' business, not ours
   // limitation: a lock is not tied to any memory range, so a
   //    misbehaving core is never stopped, only uncooperative
   // trade-off: one request per cycle keeps the hub tiny and
   //    atomic by construction, at the price of an outside
   //    arbiter when many cores share the port
   // reset: asynchronous assert, inventory and bits start empty,
   //    so the first request may follow the first edge after it

   // ==========================================================
   // state
   // ==========================================================
   logic [NUM_LOCKS-1:0] lock_bits;
   logic [NUM_LOCKS-1:0] in_use;
   logic [NUM_LOCKS-1:0] next_lock_bits;
   logic [NUM_LOCKS-1:0] next_in_use;
   logic                 rsp_valid;
   logic [RES_W-1:0]     rsp_data;
   logic                 next_rsp_valid;
   logic [RES_W-1:0]     next_rsp_data;
   logic                 take_co;         // check-out taken
   logic                 take_rel;        // release taken
   logic                 take_set;        // test-and-set taken
   logic                 take_clr;        // test-and-clear taken
   logic [NUM_LOCKS-1:0] sel;             // one-hot addressed lock
   logic [RES_W-1:0]     fr;              // lowest free lock or none

   // lowest free lock, msb set when no lock is free
   function automatic logic [RES_W-1:0] first_free(
      input logic [NUM_LOCKS-1:0] used);
      logic [RES_W-1:0] r;
      r = RES_NONE;
      for (int i = NUM_LOCKS - 1; i >= 0; i--) begin
         if (!used[i]) begin
            r = {1'b0, i[ID_W-1:0]};
         end
      end
      return r;
   endfunction

   // one-hot mask for a lock id; shared by every bit update
   function automatic logic [NUM_LOCKS-1:0] id_mask(
      input logic [ID_W-1:0] lid);
      logic [NUM_LOCKS-1:0] m;
      m      = '0;
      m[lid] = 1'b1;
      return m;
   endfunction

   // previous state of one lock bit, widened to the answer field
   function automatic logic [RES_W-1:0] old_bit(
      input logic [NUM_LOCKS-1:0] bits,
      input logic [ID_W-1:0]      lid);
      return {{(RES_W-1){1'b0}}, bits[lid]};
   endfunction

   // one request per cycle serialises all cores
   assign bus.req_ready = 1'b1;
   assign bus.rsp_valid = rsp_valid;
   assign bus.rsp_data  = rsp_data;

   // ==========================================================
   // request decode
   // ==========================================================
   // a request counts only on an edge where it is valid
   assign take_co  = bus.req_valid && (bus.req_op == SLP_OP_CHECKOUT);
   assign take_rel = bus.req_valid && (bus.req_op == SLP_OP_RELEASE);
   assign take_set = bus.req_valid && (bus.req_op == SLP_OP_SET);
   assign take_clr = bus.req_valid && (bus.req_op == SLP_OP_CLEAR);
   // id picks one of eight locks
   assign sel      = id_mask(bus.shared_lock_id);
   assign fr       = first_free(in_use);

   // ==========================================================
   // inventory of checked-out locks
   // ==========================================================
   // no owner is stored, so any core's release frees it
   always_comb begin
      next_in_use = in_use;
      if (take_co && !fr[RES_W-1]) begin
         next_in_use = in_use | id_mask(fr[ID_W-1:0]);
      end else if (take_rel) begin
         next_in_use = in_use & ~sel;
      end
   end

   // inventory register; all free after reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         in_use <= INUSE_RESET;
      end else begin
         in_use <= next_in_use;
      end
   end

   // ==========================================================
   // lock bits
   // ==========================================================
   // set/clear regardless of inventory release leaves
   // the bit alone bits gate no access anywhere
   always_comb begin
      next_lock_bits = lock_bits;
      if (take_set) begin
         next_lock_bits = lock_bits | sel;
      end else if (take_clr) begin
         next_lock_bits = lock_bits & ~sel;
      end
   end

   // lock bit register; all false after reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lock_bits <= LOCK_RESET;
      end else begin
         lock_bits <= next_lock_bits;
      end
   end

   // ==========================================================
   // answer
   // ==========================================================
   // old bit is read before this edge's update, so the answer
   // is the value the bit held when the request was taken
   always_comb begin
      next_rsp_valid = bus.req_valid;
      next_rsp_data  = rsp_data;
      if (bus.req_valid) begin
         case (bus.req_op)
            SLP_OP_CHECKOUT: begin
               next_rsp_data = fr;
            end
            SLP_OP_RELEASE: begin
               next_rsp_data = '0;
            end
            SLP_OP_SET: begin
               // old state of the addressed bit
               next_rsp_data = old_bit(lock_bits, bus.shared_lock_id);
            end
            SLP_OP_CLEAR: begin
               // old state of the addressed bit
               next_rsp_data = old_bit(lock_bits, bus.shared_lock_id);
            end
            default: begin
               next_rsp_data = '0;
            end
         endcase
      end
   end

   // answer registers; quiet after reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rsp_valid <= 1'b0;
         rsp_data  <= '0;
      end else begin
         rsp_valid <= next_rsp_valid;
         rsp_data  <= next_rsp_data;
      end
   end
endmodule : slp_hub
`default_nettype wire

// ### logic/slp_pkg.sv
// package: shared lock pool constants and command codes
`default_nettype none
package slp_pkg;
   localparam int unsigned NUM_LOCKS = 8;
   localparam int unsigned ID_W      = 3;
   localparam int unsigned RES_W     = 4;
   localparam logic [7:0]  LOCK_RESET  = 8'h00;
   localparam logic [7:0]  INUSE_RESET = 8'h00;
   // check-out result of all ones means no lock free (-1)
   localparam logic [3:0]  RES_NONE    = 4'hf;
   typedef enum logic [1:0] {
      SLP_OP_CHECKOUT,
      SLP_OP_RELEASE,
      SLP_OP_SET,
      SLP_OP_CLEAR
   } slp_op_e;
endpackage : slp_pkg
`default_nettype wire

// ### logic/slp_if.sv
// interface: request and answer wires between core side and lock hub
`default_nettype none
interface slp_if;
   logic                     req_valid;
   logic                     req_ready;
   slp_pkg::slp_op_e         req_op;
   logic [slp_pkg::ID_W-1:0] shared_lock_id;
   logic                     rsp_valid;
   logic [slp_pkg::RES_W-1:0] rsp_data;
   modport hub  (input req_valid, req_op, shared_lock_id,
                 output req_ready, rsp_valid, rsp_data);
   modport core (output req_valid, req_op, shared_lock_id,
                 input req_ready, rsp_valid, rsp_data);
endinterface : slp_if
`default_nettype wire

// ### logic/slp_core.sv
// module: core-side requester issuing one lock operation at a time
`default_nettype none
module slp_core (
   input  wire logic             clk,       // system clock
   input  wire logic             rstn,      // async reset, active low
   slp_if.core                   bus,       // link to lock hub
   input  wire logic             cmd_valid, // user request strobe
   output logic                  cmd_ready, // idle, may take request
   input  wire slp_pkg::slp_op_e cmd_op,    // operation
   input  wire logic [2:0]       cmd_id,    // lock id
   output logic                  done,      // one-cycle answer pulse
   output logic [3:0]            result     // answer value
);
   import slp_pkg::*;

   // ==========================================================
   // request holder
   // ==========================================================
   typedef enum logic [1:0] {SLP_IDLE, SLP_REQ, SLP_WAIT} slp_st_e;
   slp_st_e          st;
   slp_st_e          next_st;
   slp_op_e          op;
   slp_op_e          next_op;
   logic [ID_W-1:0]  id;
   logic [ID_W-1:0]  next_id;
   logic             done_q;
   logic             next_done;
   logic [RES_W-1:0] res_q;
   logic [RES_W-1:0] next_res;

   // retry/clear policy is left to the user
   assign cmd_ready          = (st == SLP_IDLE);
   assign bus.req_valid      = (st == SLP_REQ);
   assign bus.req_op         = op;
   assign bus.shared_lock_id = id;
   assign done               = done_q;
   assign result             = res_q;

   // next state: hold request until taken, then await answer
   always_comb begin
      next_st   = st;
      next_op   = op;
      next_id   = id;
      next_done = 1'b0;
      next_res  = res_q;
      case (st)
         SLP_IDLE: begin
            if (cmd_valid) begin
               next_op = cmd_op;
               next_id = cmd_id;
               next_st = SLP_REQ;
            end
         end
         SLP_REQ: begin
            if (bus.req_ready) begin
               next_st = SLP_WAIT;
            end
         end
         SLP_WAIT: begin
            if (bus.rsp_valid) begin
               next_res  = bus.rsp_data;
               next_done = 1'b1;
               next_st   = SLP_IDLE;
            end
         end
         default: begin
            next_st = SLP_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st     <= SLP_IDLE;
         op     <= SLP_OP_CHECKOUT;
         id     <= 3'h0;
         done_q <= 1'b0;
         res_q  <= 4'h0;
      end else begin
         st     <= next_st;
         op     <= next_op;
         id     <= next_id;
         done_q <= next_done;
         res_q  <= next_res;
      end
   end
endmodule : slp_core
`default_nettype wire

// ### tb/slp_link_monitor.sv
// checker: assertions on the core-to-hub link
`default_nettype none
module slp_link_monitor (
   input wire logic                      clk,            // clock
   input wire logic                      rstn,           // reset, low
   input wire logic                      req_valid,      // request
   input wire logic                      req_ready,      // hub ready
   input wire slp_pkg::slp_op_e          req_op,         // operation
   input wire logic [slp_pkg::ID_W-1:0]  shared_lock_id, // lock id
   input wire logic                      rsp_valid,      // answer
   input wire logic [slp_pkg::RES_W-1:0] rsp_data        // answer value
);
   timeunit 1ns;
   timeprecision 1ps;
   import slp_pkg::*;
   slp_op_e         last_op;
   logic [ID_W-1:0] last_id;
   // ==========
   // previous request, so back-to-back pairs on one id can be judged
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         last_op <= SLP_OP_CHECKOUT;
         last_id <= '0;
      end else if (req_valid) begin
         last_op <= req_op;
         last_id <= shared_lock_id;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   AST_RDY: assert property (req_ready)
      else $error("hub not ready");
   AST_ANS: assert property (req_valid |=> rsp_valid)
      else $error("request without answer");
   AST_QUIET: assert property (!req_valid |=> !rsp_valid)
      else $error("answer without request");
   AST_SET_OLD: assert property (req_valid && req_op == SLP_OP_SET
      |=> rsp_data[3:1] == 3'h0) else $error("set answer too wide");
   AST_SET_AGAIN: assert property (req_valid && req_op == SLP_OP_SET
      && last_op == SLP_OP_SET && last_id == shared_lock_id
      |=> rsp_data == 4'h1) else $error("second set not true");
   AST_CLR_SET: assert property (req_valid && req_op == SLP_OP_CLEAR
      && last_op == SLP_OP_SET && last_id == shared_lock_id
      |=> rsp_data == 4'h1) else $error("clear after set not true");
   AST_REL: assert property (req_valid && req_op == SLP_OP_RELEASE
      |=> rsp_data == 4'h0) else $error("release answer not zero");
   AST_CO: assert property (req_valid && req_op == SLP_OP_CHECKOUT
      |=> rsp_data < 4'h8 || rsp_data == RES_NONE)
      else $error("check-out answer out of range");
   // main scenarios seen
   cover property (req_valid && req_op == SLP_OP_CHECKOUT
      ##1 rsp_data == RES_NONE);
   cover property (req_valid && req_op == SLP_OP_SET ##1 rsp_data == 4'h1);
   cover property (req_valid && req_op == SLP_OP_RELEASE);
endmodule // slp_link_monitor
`default_nettype wire

// ### tb/tb.sv
// testbench: core and hub joined, lock pool scenarios
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import slp_pkg::*;
   logic clk, rstn, cmd_valid, cmd_ready, done;
   slp_op_e cmd_op;
   logic [2:0] cmd_id;
   logic [3:0] result;
   int n_fail, checked;
   slp_if link ();
   slp_hub u_slp_hub (.clk(clk), .rstn(rstn), .bus(link));
   slp_core u_slp_core (.clk(clk), .rstn(rstn), .bus(link),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
      .cmd_id(cmd_id), .done(done), .result(result));
   slp_link_monitor u_slp_link_monitor (.clk(clk), .rstn(rstn),
      .req_valid(link.req_valid), .req_ready(link.req_ready),
      .req_op(link.req_op), .shared_lock_id(link.shared_lock_id),
      .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data));
   // ==========
   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic print_verdict();
      $display("checked %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [3:0] g, input logic [3:0] e);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // one command; done must come one cycle after the take edge, on the third negedge
   task automatic op(input slp_op_e o, input logic [2:0] i,
                     input logic [3:0] e);
      int n;
      chk({3'h0, cmd_ready}, 4'h1);
      cmd_op = o;
      cmd_id = i;
      cmd_valid = 1'b1;
      @(negedge clk);
      cmd_valid = 1'b0;
      n = 1;
      while (done !== 1'b1 && n < 9) begin
         @(negedge clk);
         n++;
      end
      chk(4'(n), 4'h3);
      if (n >= 9) print_verdict();
      chk(result, e);
   endtask
   task automatic t_reset();
      for (int i = 0; i < 8; i++) op(SLP_OP_CLEAR, 3'(i), 4'h0);
      $display("reset test done");
   endtask
   task automatic t_checkout();
      for (int i = 0; i < 8; i++) op(SLP_OP_CHECKOUT, 3'h0, 4'(i));
      op(SLP_OP_CHECKOUT, 3'h0, RES_NONE);
      op(SLP_OP_RELEASE, 3'h5, 4'h0);
      op(SLP_OP_CHECKOUT, 3'h0, 4'h5);
      $display("checkout test done");
   endtask
   task automatic t_setclr();
      op(SLP_OP_SET, 3'h3, 4'h0);
      op(SLP_OP_SET, 3'h3, 4'h1);
      op(SLP_OP_CLEAR, 3'h3, 4'h1);
      op(SLP_OP_CLEAR, 3'h3, 4'h0);
      $display("set clear test done");
   endtask
   task automatic t_free();
      op(SLP_OP_RELEASE, 3'h7, 4'h0);
      op(SLP_OP_SET, 3'h7, 4'h0);
      op(SLP_OP_SET, 3'h7, 4'h1);
      op(SLP_OP_CHECKOUT, 3'h0, 4'h7);
      $display("free lock test done");
   endtask
   // one core checks out and shares the id; users retry and clear
   task automatic t_share();
      op(SLP_OP_RELEASE, 3'h2, 4'h0);
      op(SLP_OP_CHECKOUT, 3'h0, 4'h2);
      op(SLP_OP_SET, 3'h2, 4'h0);
      op(SLP_OP_SET, 3'h2, 4'h1);
      op(SLP_OP_CLEAR, 3'h2, 4'h1);
      op(SLP_OP_SET, 3'h2, 4'h0);
      $display("shared lock test done");
   endtask
   // reset for five cycles, then the scenarios
   initial begin
      rstn = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = SLP_OP_CHECKOUT;
      cmd_id = 3'h0;
      repeat (5) @(negedge clk);
      rstn = 1'b1;
      @(negedge clk);
      t_reset();
      t_checkout();
      t_setclr();
      t_free();
      t_share();
      print_verdict();
   end
endmodule // tb
`default_nettype wire
